// file: core/spcp_regs.svh
// Register offsets, field positions and key value for the serial port
// command and write-protection block. Assumes a byte-addressed port.
`ifndef SPCP_REGS_SVH
`define SPCP_REGS_SVH
`define SPCP_OFS_COMMAND      32'h400a0000
`define SPCP_OFS_PROTECT      32'h400a00e4
`define SPCP_OFS_CTRL_STAT    32'h400a00f0
`define SPCP_OFS_ERR_STAT     32'h400a00f4
`define SPCP_BIT_RX_RESET     2
`define SPCP_BIT_TX_RESET     3
`define SPCP_BIT_RX_ON        4
`define SPCP_BIT_RX_OFF       5
`define SPCP_BIT_TX_ON        6
`define SPCP_BIT_TX_OFF       7
`define SPCP_BIT_STAT_CLEAR   8
`define SPCP_BIT_PROTECT_ON   0
`define SPCP_KEY_LSB          8
`define SPCP_KEY_VALUE        24'h555341
`define SPCP_PROTECT_RESET    1'b0
`endif

// file: core/spcp_pkg.sv
// Types shared by the serial port command and protection block.
// Assumes the register header is included by the user.
package spcp_pkg;
    typedef logic [31:0] spcp_word_t;
    typedef logic [4:0]  spcp_err_t; // Parity, framing, overrun, manchester, break
endpackage : spcp_pkg

// file: core/spcp_core.sv
// Serial port command decode and write-protection key gate.
// Assumes a single 10 MHz clock and a plain synchronous register port.
// Summary of operation
// RULE_01 - Writing one to rx_reset_cmd resets the receive logic; zero does nothing.
// RULE_02 - Writing one to tx_reset_cmd resets the transmit logic; zero does nothing.
// RULE_03 - A one in rx_on_cmd enables the receiver only if rx_off_cmd is zero in that write.
// RULE_04 - A one in rx_off_cmd disables the receiver and wins over a same-write enable.
// RULE_05 - A one in tx_on_cmd enables the transmitter only if tx_off_cmd is zero.
// RULE_06 - A one in tx_off_cmd disables the transmitter and wins over an enable.
// RULE_07 - Writing one to status_clear_cmd clears the five sticky receive error flags.
// RULE_08 - protect_on_bit zero with the correct key turns write protection off.
// RULE_09 - protect_on_bit one with the correct key turns write protection on.
// RULE_10 - A protection write with a wrong key leaves protect_on_bit unchanged.
// RULE_11 - Reads of the protection register return zero in the key field.
// RULE_12 - Command bits are one-cycle pulses that hold no state.
`timescale 1ns/1ns
`include "spcp_regs.svh"
module spcp_core
    import spcp_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire spcp_err_t   err_event_i,
    output logic      [31:0] rdata_o,
    output logic             rx_reset_o,
    output logic             tx_reset_o,
    output logic             rx_enabled_o,
    output logic             tx_enabled_o,
    output logic             stat_clear_o,
    output logic             protect_on_o,
    output spcp_err_t        err_flags_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode; one compare function serves the strobes and the checks, so the
    // two can never disagree on what an address means
    function automatic logic f_hits(input logic [31:0] addr, input logic [31:0] ofs);
        return addr == ofs;
    endfunction : f_hits

    logic cmd_wr;
    logic prot_wr;
    logic key_ok;
    logic rx_rst_req;
    logic tx_rst_req;
    logic rx_on_req;
    logic rx_off_req;
    logic tx_on_req;
    logic tx_off_req;
    logic clr_req;
    assign cmd_wr     = wr_i && f_hits(addr_i, `SPCP_OFS_COMMAND);
    assign prot_wr    = wr_i && f_hits(addr_i, `SPCP_OFS_PROTECT);
    // The key is compared in full; a near miss must not move the enable
    assign key_ok     = (wdata_i[`SPCP_KEY_LSB +: 24] == `SPCP_KEY_VALUE);
    // Command bits qualified by the write strobe; none of them is stored
    assign rx_rst_req = cmd_wr && wdata_i[`SPCP_BIT_RX_RESET];
    assign tx_rst_req = cmd_wr && wdata_i[`SPCP_BIT_TX_RESET];
    assign rx_on_req  = cmd_wr && wdata_i[`SPCP_BIT_RX_ON];
    assign rx_off_req = cmd_wr && wdata_i[`SPCP_BIT_RX_OFF];
    assign tx_on_req  = cmd_wr && wdata_i[`SPCP_BIT_TX_ON];
    assign tx_off_req = cmd_wr && wdata_i[`SPCP_BIT_TX_OFF];
    assign clr_req    = cmd_wr && wdata_i[`SPCP_BIT_STAT_CLEAR];

    ////////////////////////////////////////////////////////////////////////////
    // Reset and clear pulses, one cycle after the write; no stored command state
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_reset_o   <= 1'b0;
            tx_reset_o   <= 1'b0;
            stat_clear_o <= 1'b0;
        end
        else
        begin
            rx_reset_o   <= cmd_wr && wdata_i[`SPCP_BIT_RX_RESET];   // see RULE_01 see RULE_12
            tx_reset_o   <= cmd_wr && wdata_i[`SPCP_BIT_TX_RESET];   // see RULE_02 see RULE_12
            stat_clear_o <= cmd_wr && wdata_i[`SPCP_BIT_STAT_CLEAR]; // see RULE_07
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver enable; a reset command also drops it, as in a fresh reset state
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rx_enabled_o <= 1'b0;
        else if (cmd_wr)
        begin
            if (wdata_i[`SPCP_BIT_RX_OFF] || wdata_i[`SPCP_BIT_RX_RESET])
                rx_enabled_o <= 1'b0;       // see RULE_04 see RULE_01
            else if (wdata_i[`SPCP_BIT_RX_ON])
                rx_enabled_o <= 1'b1;       // see RULE_03
        end
    end

    // Transmitter enable, same priority
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_enabled_o <= 1'b0;
        else if (cmd_wr)
        begin
            if (wdata_i[`SPCP_BIT_TX_OFF] || wdata_i[`SPCP_BIT_TX_RESET])
                tx_enabled_o <= 1'b0;       // see RULE_06 see RULE_02
            else if (wdata_i[`SPCP_BIT_TX_ON])
                tx_enabled_o <= 1'b1;       // see RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky error flags, one flop per cause; a new event wins over a clear in
    // the same cycle, so an error that lands with the clear is never lost
    localparam int ERR_W = $bits(spcp_err_t);
    genvar g_err;
    generate
        for (g_err = 0; g_err < ERR_W; g_err = g_err + 1)
        begin : g_flag
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    err_flags_o[g_err] <= 1'b0;
                else if (err_event_i[g_err])
                    err_flags_o[g_err] <= 1'b1;     // Set wins
                else if (clr_req)
                    err_flags_o[g_err] <= 1'b0;     // see RULE_07
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Protection enable, written only with the correct key
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            protect_on_o <= `SPCP_PROTECT_RESET;
        else if (prot_wr && key_ok)
            protect_on_o <= wdata_i[`SPCP_BIT_PROTECT_ON]; // see RULE_08 see RULE_09 see RULE_10
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe only; command reads as zero
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= '0;
        else if (!rd_i)
            rdata_o <= '0;
        else
        begin
            unique case (addr_i)
                `SPCP_OFS_PROTECT:   rdata_o <= {31'h0, protect_on_o}; // see RULE_11
                `SPCP_OFS_CTRL_STAT: rdata_o <= {29'h0, protect_on_o, tx_enabled_o,
                                                 rx_enabled_o};
                `SPCP_OFS_ERR_STAT:  rdata_o <= {27'h0, err_flags_o};
                default:             rdata_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks; one clock domain, so a default clock and reset keep them short
    default clocking cb_chk @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Building blocks for the multi-step checks
    sequence s_rx_rst;
        rx_rst_req;
    endsequence : s_rx_rst
    sequence s_rx_on;
        rx_on_req && !rx_off_req && !rx_rst_req;
    endsequence : s_rx_on
    sequence s_rx_off;
        rx_off_req;
    endsequence : s_rx_off
    sequence s_rx_quiet;
        !(rx_rst_req || rx_on_req || rx_off_req);
    endsequence : s_rx_quiet
    sequence s_tx_on;
        tx_on_req && !tx_off_req && !tx_rst_req;
    endsequence : s_tx_on
    sequence s_tx_off;
        tx_off_req;
    endsequence : s_tx_off
    sequence s_tx_quiet;
        !(tx_rst_req || tx_on_req || tx_off_req);
    endsequence : s_tx_quiet
    sequence s_clear_clean;
        clr_req && err_event_i == '0;
    endsequence : s_clear_clean
    sequence s_no_event;
        err_event_i == '0 && !clr_req;
    endsequence : s_no_event
    sequence s_key_on;
        prot_wr && key_ok && wdata_i[`SPCP_BIT_PROTECT_ON];
    endsequence : s_key_on
    sequence s_key_off;
        prot_wr && key_ok && !wdata_i[`SPCP_BIT_PROTECT_ON];
    endsequence : s_key_off
    sequence s_bad_key;
        prot_wr && !key_ok;
    endsequence : s_bad_key

    // Disable beats a same-write enable
    AST_RX_OFF_WINS: assert property ( // see RULE_04
        s_rx_off |=> !rx_enabled_o)
        else $error("receiver still on after disable");
    // Enable alone turns the receiver on
    AST_RX_ON: assert property ( // see RULE_03
        s_rx_on |=> rx_enabled_o)
        else $error("receiver not on after enable");
    // Disable beats a same-write enable
    AST_TX_OFF_WINS: assert property ( // see RULE_06
        s_tx_off |=> !tx_enabled_o)
        else $error("transmitter still on after disable");
    // Enable alone turns the transmitter on
    AST_TX_ON: assert property ( // see RULE_05
        s_tx_on |=> tx_enabled_o)
        else $error("transmitter not on after enable");
    // A receiver reset pulse only ever follows its command
    AST_RX_RESET_PULSE: assert property ( // see RULE_01
        rx_reset_o |-> $past(rx_rst_req))
        else $error("receiver reset without command");
    // Transmitter reset pulses and leaves the transmitter off
    AST_TX_RESET_PULSE: assert property ( // see RULE_02
        tx_rst_req |=> tx_reset_o && !tx_enabled_o)
        else $error("transmitter reset missing");
    // A clean clear empties every flag
    AST_STAT_CLEAR: assert property ( // see RULE_07
        s_clear_clean |=> err_flags_o == '0 && stat_clear_o)
        else $error("error flags not cleared");
    // Wrong key leaves the enable alone
    AST_BAD_KEY: assert property ( // see RULE_10
        s_bad_key |=> $stable(protect_on_o))
        else $error("protection changed on bad key");
    // Right key takes the written enable
    AST_GOOD_KEY: assert property ( // see RULE_08 see RULE_09
        prot_wr && key_ok |=> protect_on_o == $past(wdata_i[`SPCP_BIT_PROTECT_ON]))
        else $error("protection not taken with key");
    // Key field never reads back
    AST_KEY_READS_ZERO: assert property ( // see RULE_11
        rd_i && f_hits(addr_i, `SPCP_OFS_PROTECT) |=> rdata_o[31:1] == '0)
        else $error("key field read nonzero");
    // No command pulse without a command write
    AST_NO_CMD_STATE: assert property ( // see RULE_12
        !cmd_wr |=> !rx_reset_o && !tx_reset_o && !stat_clear_o)
        else $error("command pulse without write");

    // A receiver reset also drops the enable, as a fresh reset would
    AST_RX_RESET_DROPS: assert property ( // see RULE_01
        s_rx_rst |=> rx_reset_o && !rx_enabled_o)
        else $error("receiver reset did not take");
    // A transmitter reset pulse only ever follows its command
    AST_TX_RESET_SRC: assert property ( // see RULE_02
        tx_reset_o |-> $past(tx_rst_req))
        else $error("transmitter reset without command");
    // A clear pulse only ever follows its command
    AST_CLEAR_SRC: assert property ( // see RULE_07
        stat_clear_o |-> $past(clr_req))
        else $error("clear pulse without command");
    // Zero in every receiver bit keeps the receiver as it was
    AST_RX_QUIET_KEEPS: assert property ( // see RULE_12
        s_rx_quiet |=> $stable(rx_enabled_o))
        else $error("receiver moved without command");
    // Zero in every transmitter bit keeps the transmitter as it was
    AST_TX_QUIET_KEEPS: assert property ( // see RULE_12
        s_tx_quiet |=> $stable(tx_enabled_o))
        else $error("transmitter moved without command");
    // An enable survives a later write that carries no receiver bit
    AST_RX_ON_HOLDS: assert property ( // see RULE_03
        s_rx_on ##1 s_rx_quiet |=> rx_enabled_o)
        else $error("receiver enable lost");
    // An enable survives a later write that carries no transmitter bit
    AST_TX_ON_HOLDS: assert property ( // see RULE_05
        s_tx_on ##1 s_tx_quiet |=> tx_enabled_o)
        else $error("transmitter enable lost");
    // A disable is not undone by a later quiet write
    AST_RX_OFF_HOLDS: assert property ( // see RULE_04
        s_rx_off ##1 s_rx_quiet |=> !rx_enabled_o)
        else $error("receiver came back on");
    // A disable is not undone by a later quiet write
    AST_TX_OFF_HOLDS: assert property ( // see RULE_06
        s_tx_off ##1 s_tx_quiet |=> !tx_enabled_o)
        else $error("transmitter came back on");
    // Every event sets its flag, clear or no clear
    AST_ERR_SET: assert property ( // see RULE_07
        err_event_i != '0 |=> (err_flags_o & $past(err_event_i)) == $past(err_event_i))
        else $error("error event lost");
    // Flags hold with no event and no clear
    AST_ERR_HOLD: assert property ( // see RULE_07
        !clr_req && err_event_i == '0 |=> $stable(err_flags_o))
        else $error("error flags moved on their own");
    // A clear keeps only the events that arrive with it
    AST_CLEAR_KEEPS_NEW: assert property ( // see RULE_07
        clr_req |=> err_flags_o == $past(err_event_i))
        else $error("clear kept stale flags");
    // Flags stay empty after a clean clear while nothing happens
    AST_CLEAR_STAYS_CLEAN: assert property ( // see RULE_07
        s_clear_clean ##1 s_no_event |=> err_flags_o == '0)
        else $error("flags reappeared after clear");
    // Only a protection write may move the enable
    AST_PROT_IDLE: assert property ( // see RULE_10
        !prot_wr |=> $stable(protect_on_o))
        else $error("protection moved without write");
    // Once on, a wrong-key write cannot turn protection off
    AST_PROTECT_LOCKS: assert property ( // see RULE_10
        s_key_on ##1 s_bad_key |=> protect_on_o)
        else $error("protection dropped on bad key");
    // Once off, a wrong-key write cannot turn protection on
    AST_PROTECT_UNLOCK_HOLDS: assert property ( // see RULE_08
        s_key_off ##1 s_bad_key |=> !protect_on_o)
        else $error("protection raised on bad key");
    // Read data stands only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property ( // see RULE_11
        !rd_i |=> rdata_o == '0)
        else $error("read data without read");
    // Protection reads give the enable and zero key
    AST_PROTECT_READBACK: assert property ( // see RULE_11
        rd_i && f_hits(addr_i, `SPCP_OFS_PROTECT) |=> rdata_o == {31'h0, $past(protect_on_o)})
        else $error("protection read wrong");
    // The command register keeps nothing to read
    AST_CMD_READS_ZERO: assert property ( // see RULE_12
        rd_i && f_hits(addr_i, `SPCP_OFS_COMMAND) |=> rdata_o == '0)
        else $error("command register read nonzero");
    // A single receiver reset command gives a single-cycle pulse
    AST_PULSE_ONE_CYCLE: assert property ( // see RULE_12
        s_rx_rst ##1 !rx_rst_req |=> !rx_reset_o)
        else $error("receiver reset pulse too long");

endmodule : spcp_core

// file: dv/serial_port_command_protect_test.sv
// Self-checking bench for the serial port command and protection block.
// Assumes spcp_pkg is compiled first and spcp_regs.svh is on the include path.
`timescale 1ns/1ns
`include "spcp_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module serial_port_command_protect_test
    import spcp_pkg::*;
;
    logic       core_clk_i, rst_n_i, wr_i, rd_i;
    spcp_word_t addr_i, wdata_i, rdata_o, got;
    spcp_err_t  err_event_i, err_flags_o;
    logic       rx_reset_o, tx_reset_o, rx_enabled_o, tx_enabled_o, stat_clear_o, protect_on_o;
    int         fail_count = 0;
    int         tests_run = 0;
    localparam spcp_word_t cmd_a = `SPCP_OFS_COMMAND;
    localparam spcp_word_t prot_a = `SPCP_OFS_PROTECT;
    localparam spcp_word_t rxon = 32'h1 << `SPCP_BIT_RX_ON;
    localparam spcp_word_t rxoff = 32'h1 << `SPCP_BIT_RX_OFF;
    localparam spcp_word_t txon = 32'h1 << `SPCP_BIT_TX_ON;
    localparam spcp_word_t txoff = 32'h1 << `SPCP_BIT_TX_OFF;
    localparam spcp_word_t key = {`SPCP_KEY_VALUE, 8'h00};
    spcp_core u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .err_event_i(err_event_i),
        .rdata_o(rdata_o), .rx_reset_o(rx_reset_o), .tx_reset_o(tx_reset_o),
        .rx_enabled_o(rx_enabled_o), .tx_enabled_o(tx_enabled_o),
        .stat_clear_o(stat_clear_o), .protect_on_o(protect_on_o), .err_flags_o(err_flags_o));
    ////////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // Bus cycles: effects are judged 1 ns after the edge that takes the strobe
    task automatic wr(input spcp_word_t a, input spcp_word_t d);
        @(posedge core_clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge core_clk_i); wr_i <= 1'b0; #1;
    endtask : wr
    task automatic rd(input spcp_word_t a);
        @(posedge core_clk_i); addr_i <= a; rd_i <= 1'b1;
        @(posedge core_clk_i); rd_i <= 1'b0; #1 got = rdata_o;
    endtask : rd
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    // Enable and disable, disable winning, zero writes doing nothing
    task automatic t_enables();
        wr(cmd_a, rxon | txon); `CHK(rx_enabled_o, 1'b1)
        `CHK(tx_enabled_o, 1'b1)
        wr(cmd_a, 32'h0); `CHK({rx_enabled_o, tx_enabled_o}, 2'b11)
        wr(cmd_a, rxon | rxoff | txon | txoff); `CHK(rx_enabled_o, 1'b0)
        `CHK(tx_enabled_o, 1'b0)
        wr(cmd_a, rxon); `CHK({rx_enabled_o, tx_enabled_o}, 2'b10)
        rd(`SPCP_OFS_CTRL_STAT); `CHK(got, 32'h1)
    endtask : t_enables
    // Reset commands pulse, the receiver reset for one cycle only, and leave the other direction alone
    task automatic t_resets();
        wr(cmd_a, rxon | txon);
        wr(cmd_a, 32'h1 << `SPCP_BIT_RX_RESET); `CHK(rx_reset_o, 1'b1)
        `CHK({tx_reset_o, rx_enabled_o, tx_enabled_o}, 3'b001)
        @(posedge core_clk_i); #1 `CHK(rx_reset_o, 1'b0)
        wr(cmd_a, 32'h1 << `SPCP_BIT_TX_RESET); `CHK(tx_reset_o, 1'b1)
        `CHK({rx_reset_o, tx_enabled_o}, 2'b00)
    endtask : t_resets
    // Sticky error flags set by events, cleared by the command
    task automatic t_errors();
        @(posedge core_clk_i); err_event_i <= 5'h1f;
        @(posedge core_clk_i); err_event_i <= 5'h00; #1 `CHK(err_flags_o, 5'h1f)
        rd(`SPCP_OFS_ERR_STAT); `CHK(got, 32'h1f)
        wr(cmd_a, 32'h1 << `SPCP_BIT_STAT_CLEAR); `CHK(stat_clear_o, 1'b1)
        `CHK(err_flags_o, 5'h00)
        rd(cmd_a); `CHK(got, 32'h0)
    endtask : t_errors
    // Key gate on the protection enable; key never reads back
    task automatic t_protect();
        wr(prot_a, key | 32'h1); `CHK(protect_on_o, 1'b1)
        rd(prot_a); `CHK(got, 32'h1)
        wr(prot_a, 32'h55534000); `CHK(protect_on_o, 1'b1)
        wr(prot_a, key); `CHK(protect_on_o, 1'b0)
        wr(prot_a, 32'h1); `CHK(protect_on_o, 1'b0)
        rd(32'h400a0008); `CHK(got, 32'h0)
    endtask : t_protect
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the watchdog allows about two hundred times the expected run
    initial
    begin
        rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0;
        addr_i = 32'h0; wdata_i = 32'h0; err_event_i = 5'h00;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1; #1 `CHK(protect_on_o, `SPCP_PROTECT_RESET)
        t_enables(); t_resets(); t_errors(); t_protect();
        close_out();
    end
    initial
    begin
        #1000000 fail_count++;
        close_out();
    end
endmodule : serial_port_command_protect_test
